/* src/bms_buf2.v */
// Two-entry valid/ready buffer for the detected bit stream.
// Assumes one clock, asynchronous active-high reset and a freezing enable.
`timescale 1ns/1ps
module bms_buf2
(
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [1:0] out_data
);
  reg v0_ff;
  reg v1_ff;
  reg [1:0] d0_ff;
  reg [1:0] d1_ff;
  wire push;
  wire pop;

  assign in_ready = ~v1_ff;
  assign out_valid = v0_ff;
  assign out_data = d0_ff;
  assign push = in_valid & ~v1_ff;
  assign pop = v0_ff & out_ready;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      v0_ff <= 1'b0;
      v1_ff <= 1'b0;
      d0_ff <= 2'h0;
      d1_ff <= 2'h0;
    end
    else if (ce)
    begin
      // Head slot refills from the tail, or from the input when empty
      if (pop)
      begin
        if (v1_ff)
        begin
          d0_ff <= d1_ff;
          v1_ff <= push;
          d1_ff <= in_data;
        end
        else
        begin
          v0_ff <= push;
          d0_ff <= in_data;
        end
      end
      else if (push)
      begin
        if (v0_ff)
        begin
          v1_ff <= 1'b1;
          d1_ff <= in_data;
        end
        else
        begin
          v0_ff <= 1'b1;
          d0_ff <= in_data;
        end
      end
    end
  end
endmodule

/* src/bms_consts.vh */
// Constants for the bubble memory cycle sequencer model.
// Assumes a 10 MHz system clock and a 100 kHz rotating field.
`ifndef BMS_CONSTS_VH
`define BMS_CONSTS_VH

`define BMS_CLK_HZ 10000000
`define BMS_FIELD_HZ 100000
`define BMS_CLKS_PER_CYCLE (`BMS_CLK_HZ / `BMS_FIELD_HZ)
`define BMS_PH_W 7
`define BMS_FC_W 11
`define BMS_LOOP_LEN 2048
`define BMS_MAP_LEN 1024
`define BMS_PAGE_BITS 584
`define BMS_GEN_FIRST_TO_SWAP 597
`define BMS_GEN_LAST_TO_SWAP 14
`define BMS_SWAP_TO_REPL 1026
`define BMS_SWAP_TO_NV 2
`define BMS_REPL_TO_FIRST 91
`define BMS_PAGE_READ_DURATION 674
`define BMS_REPL_TO_SWAP 1022
`define BMS_MAP_REPLICATE_TO_DETECT_DELAY 97
`define BMS_GEN_TO_MAP_LOOP_ONE_TRANSFER 608
`define BMS_GEN_TO_MAP_LOOP_TWO_TRANSFER 605
`define BMS_MAP_XFER_TO_REPL 1028
`define BMS_STROBE_OPEN_DEG 191
`define BMS_STROBE_CLOSE_DEG 258
`define BMS_OPEN_PH ((`BMS_STROBE_OPEN_DEG * `BMS_CLKS_PER_CYCLE + 359) / 360)
`define BMS_CLOSE_PH ((`BMS_STROBE_CLOSE_DEG * `BMS_CLKS_PER_CYCLE) / 360)
`define BMS_HIST_LEN `BMS_GEN_TO_MAP_LOOP_ONE_TRANSFER
`define BMS_PIPE_LEN `BMS_MAP_REPLICATE_TO_DETECT_DELAY
`define BMS_EV_GEN 0
`define BMS_EV_SWAP 1
`define BMS_EV_CUT 2
`define BMS_EV_XFER 3
`define BMS_EV_MREPL 4
`define BMS_EV_MXFER 5
`define BMS_EV_N 6
`define BMS_RST_PIPE 6'h00

`endif

/* src/bms_seq.v */
// Cycle-level model of a block-replicate bubble memory with its map loops.
// Assumes control pulses arrive asynchronously on pins and that the
// controller keeps its own timing duties; the field runs from clk_sys.
//
// Behaviour
// - Swapped page reaches replicate gates 1026 cycles later
// - Swapped data non-volatile two cycles after swap
// - Page bits detected 91 to 674 cycles after replicate
// - Replicated page returns to swap after 1022 cycles
// - Detected one stays valid at least 50 ns
// - Map data detected 97 cycles after map replicate
// - Both map loops merged; only one holds data (the model writes both loops on every map transfer)
// - Map data reaches replicate gate 1028 cycles later
// - Delays count cycle start to cycle start
`timescale 1ns/1ps
`include "bms_consts.vh"
module bms_seq
(
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire gen_pin,
  input wire swap_pin,
  input wire repl_cut_pin,
  input wire repl_xfer_pin,
  input wire map_repl_pin,
  input wire map_xfer_n_pin,
  output reg det_out_ff,
  output reg cycle_start_ff,
  output reg nonvolatile_ff,
  output reg overrun_ff,
  output wire stream_valid,
  input wire stream_ready,
  output wire [1:0] stream_data
);
  reg [`BMS_PH_W-1:0] ph_ff;
  reg [`BMS_FC_W-1:0] fc_ff;
  reg [`BMS_EV_N-1:0] s1_ff;
  reg [`BMS_EV_N-1:0] s2_ff;
  reg [`BMS_EV_N-1:0] s3_ff;
  reg [`BMS_EV_N-1:0] lvl_ff;
  reg [`BMS_EV_N-1:0] ev_ff;
  reg [`BMS_HIST_LEN-1:0] hist_ff;
  reg page_mem [0:`BMS_PAGE_BITS-1];
  reg map1_mem [0:`BMS_MAP_LEN-1];
  reg map2_mem [0:`BMS_MAP_LEN-1];
  reg page_valid_ff;
  reg [`BMS_FC_W-1:0] page_pos_ff;
  reg nv_pend_ff;
  reg rd_on_ff;
  reg rd_hit_ff;
  reg [9:0] rd_cnt_ff;
  reg [`BMS_PIPE_LEN-1:0] mpd_ff;
  reg [`BMS_PIPE_LEN-1:0] mpv_ff;
  wire cyc_end;
  wire [`BMS_EV_N-1:0] ev_now;
  wire page_act;
  wire page_bit;
  wire map_act;
  wire det_bit;
  wire in_ready;
  wire push;
  wire [9:0] map_addr;
  wire [9:0] rd_idx;
  integer i;

  // Distance along a storage loop, wrapping at the loop length
  function [`BMS_FC_W-1:0] loop_dist;
    input [`BMS_FC_W-1:0] a;
    input [`BMS_FC_W-1:0] b;
    begin
      loop_dist = a - b;
    end
  endfunction

  // Level accepted only once the second and third stages agree
  function [`BMS_EV_N-1:0] settle;
    input [`BMS_EV_N-1:0] a;
    input [`BMS_EV_N-1:0] b;
    input [`BMS_EV_N-1:0] prev;
    begin
      settle = (a & b) | (prev & (a ^ b));
    end
  endfunction

  // Field cycle closes on the last phase step
  assign cyc_end = ce && (ph_ff == `BMS_CLKS_PER_CYCLE - 1);
  assign ev_now = ev_ff | lvl_ff;

  // Page bit i leaves the detector in cycle r+91+i
  assign page_act = rd_on_ff && (rd_cnt_ff >= `BMS_REPL_TO_FIRST);
  assign rd_idx = rd_cnt_ff - 10'h05B;
  assign page_bit = page_act && rd_hit_ff && page_mem[rd_idx];
  assign map_act = mpv_ff[`BMS_PIPE_LEN-1];
  assign det_bit = page_bit | (map_act & mpd_ff[`BMS_PIPE_LEN-1]);
  assign push = cyc_end && (page_act || map_act);

  // Map bit written at loop slot t is at the replicate gate 1028 later
  assign map_addr = fc_ff[9:0] - 10'h004;

  // Phase and field cycle counters
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ph_ff <= 7'h00;
      fc_ff <= 11'h000;
      cycle_start_ff <= 1'b0;
    end
    else if (ce)
    begin
      cycle_start_ff <= cyc_end;
      if (cyc_end)
      begin
        ph_ff <= 7'h00;
        fc_ff <= fc_ff + 11'h001;
      end
      else
      begin
        ph_ff <= ph_ff + 7'h01;
      end
    end
  end

  // Pin synchronisers; transfer-in is active low on its pin
  // Pulses under two clocks may be missed: sampling is 100 ns
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_ff <= `BMS_RST_PIPE;
      s2_ff <= `BMS_RST_PIPE;
      s3_ff <= `BMS_RST_PIPE;
      lvl_ff <= `BMS_RST_PIPE;
    end
    else if (ce)
    begin
      s1_ff <= {~map_xfer_n_pin, map_repl_pin, repl_xfer_pin, repl_cut_pin,
                swap_pin, gen_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= settle(s2_ff, s3_ff, lvl_ff);
    end
  end

  // Sticky per-cycle event flags, acted on at cycle end
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ev_ff <= `BMS_RST_PIPE;
    end
    else if (ce)
    begin
      if (cyc_end)
      begin
        ev_ff <= `BMS_RST_PIPE;
      end
      else
      begin
        ev_ff <= ev_now;
      end
    end
  end

  // Input track history: bit k was generated k+1 cycles ago
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hist_ff <= {`BMS_HIST_LEN{1'b0}};
    end
    else if (cyc_end)
    begin
      hist_ff <= {hist_ff[`BMS_HIST_LEN-2:0], ev_now[`BMS_EV_GEN]};
    end
  end

  // Swap: bit i of the page was generated 597-i cycles before
  // Only the last swapped page is held; older pages read as zero
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      page_valid_ff <= 1'b0;
      page_pos_ff <= 11'h000;
      for (i = 0; i < `BMS_PAGE_BITS; i = i + 1)
        page_mem[i] <= 1'b0;
    end
    else if (cyc_end && ev_now[`BMS_EV_SWAP])
    begin
      page_valid_ff <= 1'b1;
      page_pos_ff <= fc_ff;
      for (i = 0; i < `BMS_PAGE_BITS; i = i + 1)
        page_mem[i] <= hist_ff[`BMS_GEN_FIRST_TO_SWAP - 1 - i];
    end
  end

  // Non-volatile flag drops on swap, rises at the end of the next cycle
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      nonvolatile_ff <= 1'b1;
      nv_pend_ff <= 1'b0;
    end
    else if (cyc_end)
    begin
      if (ev_now[`BMS_EV_SWAP])
      begin
        nonvolatile_ff <= 1'b0;
        nv_pend_ff <= 1'b1;
      end
      else if (nv_pend_ff)
      begin
        nonvolatile_ff <= 1'b1;
        nv_pend_ff <= 1'b0;
      end
    end
  end

  // Data replicate: either cut or transfer seen in the cycle counts
  // Loop length 1026 + 1022 keeps the page aligned on every turn
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_on_ff <= 1'b0;
      rd_hit_ff <= 1'b0;
      rd_cnt_ff <= 10'h000;
    end
    else if (cyc_end)
    begin
      if (ev_now[`BMS_EV_CUT] || ev_now[`BMS_EV_XFER])
      begin
        rd_on_ff <= 1'b1;
        rd_cnt_ff <= 10'h001;
        rd_hit_ff <= page_valid_ff &&
          (loop_dist(fc_ff, page_pos_ff) == `BMS_SWAP_TO_REPL);
      end
      else if (rd_on_ff)
      begin
        if (rd_cnt_ff == `BMS_PAGE_READ_DURATION)
        begin
          rd_on_ff <= 1'b0;
        end
        rd_cnt_ff <= rd_cnt_ff + 10'h001;
      end
    end
  end

  // Map transfer-in: each loop takes the bit at its own track tap
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < `BMS_MAP_LEN; i = i + 1)
      begin
        map1_mem[i] <= 1'b0;
        map2_mem[i] <= 1'b0;
      end
    end
    else if (cyc_end && ev_now[`BMS_EV_MXFER])
    begin
      map1_mem[fc_ff[9:0]] <= hist_ff[`BMS_GEN_TO_MAP_LOOP_ONE_TRANSFER - 1];
      map2_mem[fc_ff[9:0]] <= hist_ff[`BMS_GEN_TO_MAP_LOOP_TWO_TRANSFER - 1];
    end
  end

  // Map replicate: merged loop outputs delayed to the detector
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mpd_ff <= {`BMS_PIPE_LEN{1'b0}};
      mpv_ff <= {`BMS_PIPE_LEN{1'b0}};
    end
    else if (cyc_end)
    begin
      mpd_ff <= {mpd_ff[`BMS_PIPE_LEN-2:0],
                 map1_mem[map_addr] | map2_mem[map_addr]};
      mpv_ff <= {mpv_ff[`BMS_PIPE_LEN-2:0], ev_now[`BMS_EV_MREPL]};
    end
  end

  // Detector pin shows the cycle's bit through the whole strobe window
  // Holding the full window keeps a one far longer than 50 ns
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      det_out_ff <= 1'b0;
    end
    else if (ce)
    begin
      det_out_ff <= det_bit && (ph_ff >= `BMS_OPEN_PH - 1) &&
        (ph_ff < `BMS_CLOSE_PH);
    end
  end

  // The field cannot wait, so a full buffer drops and flags the bit
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      overrun_ff <= 1'b0;
    end
    else if (ce && push && !in_ready)
    begin
      overrun_ff <= 1'b1;
    end
  end

  bms_buf2 u_buf
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data({map_act, det_bit}),
    .out_valid(stream_valid),
    .out_ready(stream_ready),
    .out_data(stream_data)
  );
endmodule

/* tb/bms_chk.sv */
// Port assertions for the bubble memory sequencer.
// Assumes one clock domain; a low ce freezes the block.
`timescale 1ns/1ps
module bms_chk
(
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire cycle_start_ff,
  input wire nonvolatile_ff,
  input wire det_out_ff,
  input wire overrun_ff,
  input wire stream_valid,
  input wire stream_ready,
  input wire [1:0] stream_data
);
  default clocking @(posedge clk_sys); endclocking
  // Frozen field stretches every count
  default disable iff (rst || !ce);
  property p_cyc;
    cycle_start_ff |=> !cycle_start_ff [*8] ##92 cycle_start_ff;
  endproperty
  a_cyc: assert property (p_cyc) else $error("field cycle not 100 clocks");
  property p_nv_win;
    $fell(nonvolatile_ff) |-> ##99 !nonvolatile_ff ##1 nonvolatile_ff;
  endproperty
  a_nv_win: assert property (p_nv_win) else $error("volatile span wrong");
  property p_nv_edge;
    $fell(nonvolatile_ff) |-> cycle_start_ff;
  endproperty
  a_nv_edge: assert property (p_nv_edge) else $error("volatile off cycle edge");
  property p_det_hold;
    $rose(det_out_ff) |-> det_out_ff [*8];
  endproperty
  a_det_hold: assert property (p_det_hold) else $error("detected one too short");
  property p_det_win;
    det_out_ff |-> !cycle_start_ff;
  endproperty
  a_det_win: assert property (p_det_win) else $error("detector high at phase 0");
  property p_push_edge;
    $rose(stream_valid) |-> cycle_start_ff;
  endproperty
  a_push_edge: assert property (p_push_edge) else $error("word off cycle end");
  property p_ovr_cause;
    $rose(overrun_ff) |-> $past(stream_valid && !stream_ready);
  endproperty
  a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without stall");
  property p_buf_hold;
    stream_valid && !stream_ready |=> stream_valid && $stable(stream_data);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("stalled word lost");
endmodule

bind bms_seq bms_chk i_bms_chk
(
  .clk_sys, .rst, .ce, .cycle_start_ff, .nonvolatile_ff, .det_out_ff, .overrun_ff,
  .stream_valid, .stream_ready, .stream_data
);

/* tb/bms_ctl.sv */
// Controller model: places pin pulses by field phase, stalls on hold.
// Assumes cycle_start_ff marks phase 0; req is read at cycle start.
`timescale 1ns/1ps
module bms_ctl
(
  input wire clk_sys,
  input wire cycle_start_ff,
  input wire [2:0] req,
  input wire hold,
  output reg swap_pin = 1'h0,
  output reg repl_cut_pin = 1'h0,
  output reg repl_xfer_pin = 1'h0,
  output reg map_repl_pin = 1'h0,
  output reg stream_ready = 1'h1,
  output integer cyc = 0
);
  integer ph = 0;
  reg [2:0] act = 3'h0;
  always @(negedge clk_sys)
  begin
    if (cycle_start_ff)
    begin
      ph = 0;
      cyc = cyc + 1;
      act = req;
    end
    else
      ph = ph + 1;
    // Short swap keeps the pulse inside one cycle
    swap_pin <= act[0] && ph >= 80 && ph <= 82;
    repl_cut_pin <= act[1] && ph == 0;
    repl_xfer_pin <= act[1] && ph >= 1 && ph <= 28;
    map_repl_pin <= act[2] && ph <= 28;
    stream_ready <= !hold;
  end
endmodule

/* tb/tb.sv */
// Self-checking bench for the bubble memory sequencer.
// Assumes the controller model and the port checker beside it.
`timescale 1ns/1ps
module tb;
  reg clk_sys = 1'h0;
  reg rst = 1'h1;
  reg [2:0] req = 3'h0;
  reg hold = 1'h0;
  reg [1:0] exp_d = 2'h0;
  wire swap_pin, repl_cut_pin, repl_xfer_pin, map_repl_pin, stream_ready;
  wire det_out_ff, cycle_start_ff, nonvolatile_ff, overrun_ff, stream_valid;
  wire [1:0] stream_data;
  integer cyc, m, n_fail = 0, checks_done = 0, nw = 0, wc = 0;
  always #50 clk_sys = ~clk_sys;
  bms_seq i_bms_seq
  (
    .clk_sys, .rst, .ce(1'h1), .gen_pin(1'h0), .swap_pin, .repl_cut_pin,
    .repl_xfer_pin, .map_repl_pin, .map_xfer_n_pin(1'h1), .det_out_ff,
    .cycle_start_ff, .nonvolatile_ff, .overrun_ff, .stream_valid,
    .stream_ready, .stream_data
  );
  bms_ctl i_bms_ctl
  (
    .clk_sys, .cycle_start_ff, .req, .hold, .swap_pin, .repl_cut_pin,
    .repl_xfer_pin, .map_repl_pin, .stream_ready, .cyc
  );
  task print_verdict;
  begin
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task chk(input ok, input string s);
  begin
    checks_done = checks_done + 1;
    if (!ok)
    begin
      n_fail = n_fail + 1;
      $display("Error at %0t: %s", $time, s);
    end
  end
  endtask
  always @(posedge clk_sys)
    if (stream_valid && stream_ready)
    begin
      nw = nw + 1;
      wc = cyc;
      chk(stream_data === exp_d, "stream word");
    end
  // Waits to mid-cycle of cycle n
  task wait_to(input integer n);
    integer k;
  begin
    k = 0;
    while (cyc < n && k < 80000)
    begin
      @(negedge clk_sys);
      k = k + 1;
    end
    if (k >= 80000)
    begin
      chk(1'h0, "timeout");
      print_verdict;
    end
    repeat (50) @(negedge clk_sys);
  end
  endtask
  task fire(input [2:0] r);
    integer k;
  begin
    @(posedge clk_sys);
    req = r;
    k = cyc;
    repeat (102) if (cyc == k) @(posedge clk_sys);
    chk(cyc != k, "no cycle start");
    m = cyc;
    req = 3'h0;
  end
  endtask
  task t_swap;
  begin
    fire(3'h1);
    wait_to(m);
    chk(nonvolatile_ff === 1'h1, "volatile too early");
    wait_to(m + 1);
    chk(nonvolatile_ff === 1'h0, "volatile missing");
    wait_to(m + 2);
    chk(nonvolatile_ff === 1'h1, "volatile too long");
  end
  endtask
  task t_map;
  begin
    exp_d = 2'h2;
    nw = 0;
    fire(3'h4);
    wait_to(m + 99);
    chk(nw === 1 && wc === m + 98, "map word count or cycle");
  end
  endtask
  task t_repl;
  begin
    exp_d = 2'h0;
    nw = 0;
    fire(3'h2);
    hold = 1'h1;
    wait_to(m + 93);
    chk(overrun_ff === 1'h0 && stream_valid === 1'h1, "first words");
    wait_to(m + 94);
    chk(overrun_ff === 1'h1, "no overrun");
    @(posedge clk_sys);
    hold = 1'h0;
    wait_to(m + 676);
    chk(nw === 583 && stream_valid === 1'h0, "page word count");
  end
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys);
    chk(nonvolatile_ff === 1'h1 && stream_valid === 1'h0, "reset");
    chk(overrun_ff === 1'h0 && det_out_ff === 1'h0, "reset");
    rst = 1'h0;
    t_swap;
    t_map;
    t_repl;
    print_verdict;
  end
endmodule
